// >>> rtl/e1rx_defs.svh
// Purpose: constants of the e1 receive output stage
// Assumes: 32-bit axi4-lite data, 8-bit byte address
// Notes: field layout of the control word lives in e1rx_pkg
`ifndef E1RX_DEFS_SVH
`define E1RX_DEFS_SVH

`define E1RX_ADDR_W      8
`define E1RX_CTRL_ADDR   8'h00
`define E1RX_STAT_ADDR   8'h04
`define E1RX_CTRL_W      10
`define E1RX_CTRL_RST    10'h000
`define E1RX_RESP_OKAY   2'h0
`define E1RX_RESP_SLVERR 2'h2
`define E1RX_STAT_PEND   0
`define E1RX_STAT_UNI    1
`define E1RX_STAT_FCNT   8
`define E1RX_LINE_KHZ    2048
`define E1RX_LAST_BIT    8'hFF
`define E1RX_MF_LAST     4'hF
`define E1RX_HDB3_DEPTH  4

`endif

// >>> rtl/e1rx_pkg.sv
// Purpose: types shared by the e1 receive output stage
// Assumes: nothing beyond e1rx_defs.svh
// Notes: cfg_t is the bit layout of the control register
package e1rx_pkg;

	typedef enum logic [1:0] {
		E1RX_FP_FRAME = 2'b00,
		E1RX_FP_SIG   = 2'b01,
		E1RX_FP_CRC   = 2'b10,
		E1RX_FP_COMP  = 2'b11
	} e1rx_fp_mode_t;

	typedef enum logic [1:0] {
		E1RX_SRC_ANALOG = 2'b00,
		E1RX_SRC_RZ     = 2'b01,
		E1RX_SRC_NRZ    = 2'b10
	} e1rx_src_t;

	typedef struct packed {
		logic          crc_en;
		logic          smf_en;
		logic          dig_in_en;
		logic          unipolar;
		e1rx_src_t     src;
		logic          raw_sel;
		logic          decode_en;
		e1rx_fp_mode_t mode;
	} e1rx_cfg_t;

	typedef struct packed {
		logic frame_start;
		logic sig_mf_start;
		logic crc_mf_start;
		logic fas_frame;
	} e1rx_align_t;

	typedef struct packed {
		logic        pos;
		logic        neg;
		logic        single;
		e1rx_align_t al;
	} e1rx_line_t;

	typedef struct packed {
		logic        dec;
		logic        raw;
		e1rx_align_t al;
	} e1rx_ent_t;

endpackage

// >>> rtl/e1rx_out.sv
// Purpose: e1 receive output stage: recovered clock, pcm data, frame pulse
// Assumes: framer alignment flags arrive with the line bits on the line clock
// Notes: config crosses by toggle handshake, frame events by toggle
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`include "e1rx_defs.svh"

// Function
// - recovered clock output runs at 2.048 MHz, locked to the reference when src selects analog recovery.
// - clock comes from analog recovery, dual-rail rz rails, or external nrz clock.
// - decoded output carries hdb3-decoded data when decode_en is set and raw_sel is clear, held low while raw_sel is set, changing on falling edges.
// - raw output carries undecoded data only while raw_sel is set, held low otherwise, also changing on falling edges.
// - frame mode: one-cycle pulse on bit 1 of every 256-bit frame.
// - signalling mode: pulse on bit 1 of frame 1 of each signalling multiframe.
// - signalling multiframing off: pulse still marks every sixteenth frame.
// - crc mode: pulse on bit 1 of frame 1 of each crc multiframe.
// - crc multiframing off: pulse still marks a fas frame every sixteen frames.
// - composite mode: pulse rises at start of signalling multiframe bit 1.
// - composite mode: pulse falls at end of crc multiframe bit 1.
// - composite mode: coincident alignments give one single-cycle pulse.
// - in unipolar operation the pulse carries no alignment.
// - pulse changes only on falling edges of the recovered clock.
module e1rx_out (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    aclk_en,
	input  wire logic [`E1RX_ADDR_W-1:0] awaddr,
	input  wire logic [2:0]              awprot,
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	input  wire logic                    wvalid,
	output logic                         wready,
	output logic [1:0]                   bresp,
	output logic                         bvalid,
	input  wire logic                    bready,
	input  wire logic [`E1RX_ADDR_W-1:0] araddr,
	input  wire logic [2:0]              arprot,
	input  wire logic                    arvalid,
	output logic                         arready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	output logic                         rvalid,
	input  wire logic                    rready,
	input  wire logic                    reference_locked_clk,
	input  wire logic                    external_line_clock_in,
	input  wire logic                    positive_rail_input,
	input  wire logic                    negative_rail_input,
	input  wire logic                    single_rail_data_in,
	input  wire e1rx_pkg::e1rx_align_t   framer_align,
	output logic                         recovered_line_clock_out,
	output logic                         decoded_receive_data_out,
	output logic                         raw_receive_data_out,
	output logic                         receive_alignment_pulse
);
	import e1rx_pkg::*;

	e1rx_cfg_t                 ctrl;
	e1rx_cfg_t                 cfg_sh;
	e1rx_cfg_t                 lcfg;
	logic                      rclk;
	logic                      aw_hold;
	logic                      w_hold;
	logic [`E1RX_ADDR_W-1:0]   wa;
	logic [31:0]               wd;
	logic [3:0]                ws;
	logic                      wr_fire;
	logic                      req;
	logic                      ack_s1;
	logic                      ack_s2;
	logic                      ft_s1;
	logic                      ft_s2;
	logic                      ft_s3;
	logic [7:0]                fcnt;
	logic                      pend;
	logic                      lrs1;
	logic                      lrst_n;
	logic                      lce_s1;
	logic                      lce;
	logic                      req_s1;
	logic                      req_s2;
	logic                      req_s3;
	logic                      ftog;
	e1rx_line_t                in_s1;
	e1rx_line_t                in_s2;
	logic                      last_pol;
	logic                      uni;
	logic                      mark;
	logic                      viol;
	e1rx_ent_t                 dl [`E1RX_HDB3_DEPTH];
	e1rx_ent_t                 ob;
	logic [7:0]                bit_idx;
	logic [3:0]                sig_frm;
	logic [3:0]                crc_frm;
	logic [7:0]                next_idx;
	logic [3:0]                next_sig;
	logic [3:0]                next_crc;
	logic                      frame_hit;
	logic                      sig_hit;
	logic                      crc_hit;
	logic                      next_pulse;
	logic                      hold;
	logic                      pulse_q;
	logic                      data_q;

	// clock selection is quasi-static; changing src glitches rclk, so
	// software should only change it while the downstream ignores output
	always_comb
	begin
		unique case (ctrl.src)
			E1RX_SRC_ANALOG: rclk = reference_locked_clk;
			E1RX_SRC_RZ:     rclk = positive_rail_input | negative_rail_input;
			default:         rclk = external_line_clock_in;
		endcase
	end
	assign recovered_line_clock_out = rclk;

	// axi4-lite slave
	assign awready = aclk_en && !aw_hold && !bvalid;
	assign wready  = aclk_en && !w_hold && !bvalid;
	assign arready = aclk_en && !rvalid;
	assign wr_fire = aclk_en && aw_hold && w_hold && !bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			wa      <= '0;
			wd      <= '0;
			ws      <= '0;
			bvalid  <= 1'b0;
			bresp   <= `E1RX_RESP_OKAY;
		end
		else if (aclk_en)
		begin
			if (awvalid && awready)
			begin
				aw_hold <= 1'b1;
				wa      <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_hold <= 1'b1;
				wd     <= wdata;
				ws     <= wstrb;
			end
			if (wr_fire)
			begin
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (wa == `E1RX_CTRL_ADDR || wa == `E1RX_STAT_ADDR) ?
					`E1RX_RESP_OKAY : `E1RX_RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl <= `E1RX_CTRL_RST;
		else if (wr_fire && wa == `E1RX_CTRL_ADDR)
		begin
			// mode field is two bits, so exactly one pulse mode is live
			if (ws[0])
				ctrl[7:0] <= wd[7:0];
			if (ws[1])
				ctrl[`E1RX_CTRL_W-1:8] <= wd[`E1RX_CTRL_W-1:8];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= `E1RX_RESP_OKAY;
		end
		else if (aclk_en)
		begin
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rresp  <= `E1RX_RESP_OKAY;
				rdata  <= '0;
				if (araddr == `E1RX_CTRL_ADDR)
					rdata[`E1RX_CTRL_W-1:0] <= ctrl;
				else if (araddr == `E1RX_STAT_ADDR)
				begin
					rdata[`E1RX_STAT_PEND] <= pend;
					rdata[`E1RX_STAT_UNI] <= ctrl.unipolar && ctrl.dig_in_en;
					rdata[`E1RX_STAT_FCNT +: 8] <= fcnt;
				end
				else
					rresp <= `E1RX_RESP_SLVERR;
			end
			else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end

	// config toggle handshake: shadow only moves once the link took it
	assign pend = (req != ack_s2) || (cfg_sh != ctrl);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_sh <= `E1RX_CTRL_RST;
			req    <= 1'b0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end
		else if (aclk_en)
		begin
			ack_s1 <= req_s3;
			ack_s2 <= ack_s1;
			if (req == ack_s2 && cfg_sh != ctrl)
			begin
				cfg_sh <= ctrl;
				req    <= ~req;
			end
		end
	end

	// frame counter fed by a toggle from the link domain
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ft_s1 <= 1'b0;
			ft_s2 <= 1'b0;
			ft_s3 <= 1'b0;
			fcnt  <= '0;
		end
		else if (aclk_en)
		begin
			ft_s1 <= ftog;
			ft_s2 <= ft_s1;
			ft_s3 <= ft_s2;
			if (ft_s2 != ft_s3)
				fcnt <= fcnt + 8'h01;
		end
	end

	// link domain reset and enable, synchronised to rclk
	always_ff @(posedge rclk)
	begin
		lrs1   <= aresetn;
		lrst_n <= lrs1;
		lce_s1 <= aclk_en;
		lce    <= lce_s1;
	end

	always_ff @(posedge rclk)
	begin
		if (!lrst_n)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
			lcfg   <= `E1RX_CTRL_RST;
		end
		else if (lce)
		begin
			req_s1 <= req;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			if (req_s2 != req_s3)
				lcfg <= cfg_sh;
		end
	end

	// two sampling stages on the line pins
	always_ff @(posedge rclk)
	begin
		if (!lrst_n)
		begin
			in_s1 <= '0;
			in_s2 <= '0;
		end
		else if (lce)
		begin
			in_s1 <= {positive_rail_input, negative_rail_input,
				single_rail_data_in, framer_align};
			in_s2 <= in_s1;
		end
	end

	assign uni  = lcfg.unipolar && lcfg.dig_in_en;
	assign mark = uni ? in_s2.single : (in_s2.pos || in_s2.neg);
	// a mark with the same polarity as the previous one is a violation
	assign viol = !uni && lcfg.decode_en && mark && (in_s2.pos == last_pol);

	always_ff @(posedge rclk)
	begin
		if (!lrst_n)
			last_pol <= 1'b0;
		else if (lce && mark && !uni)
			last_pol <= in_s2.pos;
	end

	// four-bit window: a violation zeroes itself and the three bits before
	genvar g;
	for (g = 0; g < `E1RX_HDB3_DEPTH; g++)
	begin : g_hdb3
		// head and tail split so no stage ever names an entry below zero
		if (g == 0)
		begin : g_head
			always_ff @(posedge rclk)
			begin
				if (!lrst_n)
					dl[g] <= '0;
				else if (lce)
					dl[g] <= '{dec: mark && !viol, raw: mark, al: in_s2.al};
			end
		end
		else
		begin : g_tail
			always_ff @(posedge rclk)
			begin
				if (!lrst_n)
					dl[g] <= '0;
				else if (lce)
				begin
					dl[g]     <= dl[g-1];
					dl[g].dec <= dl[g-1].dec && !viol;
				end
			end
		end
	end

	assign ob = dl[`E1RX_HDB3_DEPTH-1];

	// bit and frame position of the bit leaving the window
	always_comb
	begin
		next_idx = ob.al.frame_start ? 8'h00 : bit_idx + 8'h01;
		frame_hit = (next_idx == 8'h00);
		next_sig = sig_frm;
		next_crc = crc_frm;
		if (frame_hit)
		begin
			next_sig = (lcfg.smf_en && ob.al.sig_mf_start) ? 4'h0 : sig_frm + 4'h1;
			next_crc = (lcfg.crc_en && ob.al.crc_mf_start) ? 4'h0 : crc_frm + 4'h1;
			// free running count is pulled onto fas frames
			if (!lcfg.crc_en && next_crc == 4'h0 && !ob.al.fas_frame)
				next_crc = `E1RX_MF_LAST;
		end
		sig_hit = frame_hit && next_sig == 4'h0;
		crc_hit = frame_hit && next_crc == 4'h0;
		unique case (lcfg.mode)
			E1RX_FP_FRAME: next_pulse = frame_hit;
			E1RX_FP_SIG:   next_pulse = sig_hit;
			E1RX_FP_CRC:   next_pulse = crc_hit;
			E1RX_FP_COMP:  next_pulse = sig_hit || hold;
		endcase
		if (uni)
			next_pulse = 1'b0;
	end

	always_ff @(posedge rclk)
	begin
		if (!lrst_n)
		begin
			bit_idx <= `E1RX_LAST_BIT;
			sig_frm <= `E1RX_MF_LAST;
			crc_frm <= `E1RX_MF_LAST;
			hold    <= 1'b0;
			pulse_q <= 1'b0;
			data_q  <= 1'b0;
			ftog    <= 1'b0;
		end
		else if (lce)
		begin
			bit_idx <= next_idx;
			sig_frm <= next_sig;
			crc_frm <= next_crc;
			// composite level drops after the crc bit 1
			hold    <= (lcfg.mode == E1RX_FP_COMP) && next_pulse && !crc_hit;
			pulse_q <= next_pulse;
			data_q  <= lcfg.raw_sel ? ob.raw : ob.dec;
			if (frame_hit)
				ftog <= ~ftog;
		end
	end

	// outputs move on falling edges so the far side samples on rising
	always_ff @(negedge rclk)
	begin
		if (!lrst_n)
		begin
			receive_alignment_pulse  <= 1'b0;
			decoded_receive_data_out <= 1'b0;
			raw_receive_data_out     <= 1'b0;
		end
		else if (lce)
		begin
			receive_alignment_pulse  <= pulse_q;
			decoded_receive_data_out <= !lcfg.raw_sel && data_q;
			raw_receive_data_out     <= lcfg.raw_sel && data_q;
		end
	end

	sequence s_ar_taken;
		arvalid && arready;
	endsequence

	sequence s_wr_done;
		wr_fire ##1 bvalid;
	endsequence

	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ar_taken |=> rvalid)
		else $error("read not answered next cycle");
	a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		s_wr_done |-> !awready && !wready)
		else $error("write accepted while response pending");
	a_frame_pulse: assert property (@(posedge rclk) disable iff (!lrst_n)
		lcfg.mode == E1RX_FP_FRAME && next_pulse |-> next_idx == 8'h00)
		else $error("frame pulse off bit 1");
	a_sig_mframe: assert property (@(posedge rclk) disable iff (!lrst_n)
		lcfg.mode == E1RX_FP_SIG && next_pulse |-> next_sig == 4'h0 && frame_hit)
		else $error("signalling pulse off frame 1");
	a_crc_mframe: assert property (@(posedge rclk) disable iff (!lrst_n)
		lcfg.mode == E1RX_FP_CRC && next_pulse |-> next_crc == 4'h0 && frame_hit)
		else $error("crc pulse off frame 1");
	a_comp_fall: assert property (@(posedge rclk) disable iff (!lrst_n) lce &&
		lcfg.mode == E1RX_FP_COMP && crc_hit && !sig_hit |=> !next_pulse || sig_hit)
		else $error("composite pulse did not fall");
	sequence s_coincide;
		lce && !uni && lcfg.mode == E1RX_FP_COMP && sig_hit && crc_hit ##1 lce;
	endsequence

	a_comp_single: assert property (@(posedge rclk) disable iff (!lrst_n)
		s_coincide |-> pulse_q && !next_pulse)
		else $error("coincident composite pulse too long");
	a_uni_quiet: assert property (@(posedge rclk) disable iff (!lrst_n)
		uni |-> !next_pulse)
		else $error("pulse during unipolar");
	a_hdb3_clear: assert property (@(posedge rclk) disable iff (!lrst_n)
		lce && viol |=> !dl[0].dec && !dl[1].dec && !dl[2].dec && !dl[3].dec)
		else $error("violation not cleared");
	a_pulse_falling: assert property (@(posedge rclk) disable iff (!lrst_n)
		lce ##1 lce |-> receive_alignment_pulse == pulse_q)
		else $error("pulse output out of step");

endmodule

// >>> bench/e1rx_sink.sv
// Purpose: downstream logic sampling the recovered pcm stream
// Assumes: data and pulse change on falling recovered clock
// Notes: latch stage only, no alignment search of its own
`timescale 1ns/1ns
module e1rx_sink (
	input  wire logic rclk,
	input  wire logic dec,
	input  wire logic raw,
	input  wire logic pulse,
	output logic      s_dec,
	output logic      s_raw,
	output logic      s_pulse
);
	// rising edge sits mid-bit, far from the falling update
	always_ff @(posedge rclk)
	begin
		s_dec   <= dec;
		s_raw   <= raw;
		s_pulse <= pulse;
	end
endmodule

// >>> bench/tb.sv
// Purpose: self-checking bench of the e1 receive output stage
// Assumes: analog and external clock sources both carry the bench line clock
// Notes: link results are compared half a bit period after sampling
`timescale 1ns/1ns
`include "e1rx_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
	import e1rx_pkg::*;
	logic          aclk    = 1'b0;
	logic          aresetn = 1'b0;
	logic          rclk    = 1'b0;
	logic [7:0]    awaddr  = 8'h00;
	logic [7:0]    araddr  = 8'h00;
	logic [31:0]   wdata   = 32'h0;
	logic          awvalid = 1'b0;
	logic          wvalid  = 1'b0;
	logic          bready  = 1'b0;
	logic          arvalid = 1'b0;
	logic          rready  = 1'b0;
	logic          pos     = 1'b0;
	logic          neg     = 1'b0;
	logic          single  = 1'b0;
	e1rx_align_t   al      = '0;
	logic [31:0]   rdata;
	logic [1:0]    bresp;
	logic [1:0]    rresp;
	logic          awready, wready, bvalid, arready, rvalid;
	logic          rclk_out, dec, raw, pulse, s_dec, s_raw, s_pulse;
	int            bad_count = 0;
	int            n_tests   = 0;
	logic [31:0]   seed      = 32'h000139D2;
	logic [1:0]    bq[$];
	logic [65:0]   rq[$];
	logic [2:0]    lq[$];
	e1rx_fp_mode_t mode      = E1RX_FP_FRAME;
	logic          use_raw   = 1'b0;
	logic          uni       = 1'b0;
	logic          chk_on    = 1'b0;
	logic          lpol      = 1'b0;
	logic          dec_on    = 1'b0;
	logic          line_on   = 1'b0;
	logic          hold      = 1'b0;
	logic [3:0]    crc_off   = 4'h2;
	logic [7:0]    bit_c     = 8'h00;
	logic [3:0]    frm_c     = 4'h0;

	initial forever #10 aclk = ~aclk;
	// odd start offset keeps the link clock out of phase with aclk
	initial
	begin
		#7;
		forever #32 rclk = ~rclk;
	end

	e1rx_out i_dut (.aclk(aclk), .aresetn(aresetn), .aclk_en(1'b1), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.reference_locked_clk(rclk), .external_line_clock_in(rclk),
		.positive_rail_input(pos), .negative_rail_input(neg),
		.single_rail_data_in(single), .framer_align(al),
		.recovered_line_clock_out(rclk_out), .decoded_receive_data_out(dec),
		.raw_receive_data_out(raw), .receive_alignment_pulse(pulse));

	e1rx_sink i_sink (.rclk(rclk_out), .dec(dec), .raw(raw), .pulse(pulse),
		.s_dec(s_dec), .s_raw(s_raw), .s_pulse(s_pulse));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// framer flags on bit 1; the note holds what the stream must show
	always @(posedge rclk)
	begin : drv
		logic s, c, p, m, v;
		logic [2:0] t;
		seed = lfsr(seed);
		// line quiet until line_on, so both polarity memories start at zero
		m = seed[0] & line_on;
		v = dec_on & m & ~uni & (seed[1] == lpol);
		if (m & ~uni)
			lpol = seed[1];
		// a violation also blanks the three decoded bits before it
		if (v)
			for (int i = 1; i < 4; i++)
			begin
				t = lq[lq.size() - i];
				t[2] = 1'b0;
				lq[lq.size() - i] = t;
			end
		s = (bit_c == 8'h00) && (frm_c == 4'h0);
		c = (bit_c == 8'h00) && (frm_c == crc_off);
		case (mode)
			E1RX_FP_FRAME: p = (bit_c == 8'h00);
			E1RX_FP_SIG:   p = s;
			E1RX_FP_CRC:   p = c;
			default:       p = s | hold;
		endcase
		if (uni)
			p = 1'b0;
		hold <= (s | hold) & ~c;
		al <= '{frame_start: bit_c == 8'h00, sig_mf_start: s, crc_mf_start: c,
			fas_frame: ~frm_c[0]};
		pos <= m & seed[1];
		neg <= m & ~seed[1];
		single <= seed[2];
		lq.push_back({~use_raw & m & ~v, use_raw & (uni ? seed[2] : m), p});
		bit_c <= bit_c + 8'h01;
		if (bit_c == 8'hFF)
			frm_c <= frm_c + 4'h1;
	end

	always @(negedge rclk)
	begin : lwatch
		logic [2:0] e;
		if (lq.size() > 8)
		begin
			e = lq.pop_front();
			if (chk_on)
			begin
				`CHK("pulse", e[0], s_pulse)
				// decoded data is meaningless in unipolar mode
				if (!uni) `CHK("dec", e[2], s_dec)
				`CHK("raw", e[1], s_raw)
			end
		end
	end

	always @(posedge aclk)
	begin : awatch
		logic [65:0] e;
		// aclk edges never meet rclk edges, so both clocks are settled here
		if (aresetn)
			`CHK("rclk", rclk, rclk_out)
		if (bvalid && bready)
		begin
			e[1:0] = bq.pop_front();
			`CHK("bresp", e[1:0], bresp)
		end
		if (rvalid && rready)
		begin
			e = rq.pop_front();
			`CHK("rdata", e[31:0], rdata & e[63:32])
			`CHK("rresp", e[65:64], rresp)
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] r);
		rq.push_back({r, m, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// frame 15 is quiet, so composite state is known from there on
	task automatic run(input logic [9:0] c, input logic w, input int nb);
		chk_on = 1'b0;
		wr(`E1RX_CTRL_ADDR, {22'h0, c}, `E1RX_RESP_OKAY);
		rd(`E1RX_CTRL_ADDR, {22'h0, c}, 32'hFFFFFFFF, `E1RX_RESP_OKAY);
		mode = e1rx_fp_mode_t'(c[1:0]);
		use_raw = c[3];
		uni = c[6] & c[7];
		dec_on = c[2];
		repeat (40) @(posedge rclk);
		@(posedge aclk);
		rd(`E1RX_STAT_ADDR, {30'h0, uni, 1'b0}, 32'h00000003, `E1RX_RESP_OKAY);
		if (w)
			@(posedge rclk iff frm_c == 4'hF);
		chk_on = 1'b1;
		repeat (nb) @(posedge rclk);
		@(posedge aclk);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#2_000_000;
		bad_count++;
		results();
	end

	initial
	begin
		repeat (6) @(posedge rclk);
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`E1RX_CTRL_ADDR, 32'h0, 32'hFFFFFFFF, `E1RX_RESP_OKAY);
		rd(8'h08, 32'h0, 32'hFFFFFFFF, `E1RX_RESP_SLVERR);
		wr(8'h08, 32'h3FF, `E1RX_RESP_SLVERR);
		wr(`E1RX_STAT_ADDR, 32'hFFFF, `E1RX_RESP_OKAY);
		rd(`E1RX_CTRL_ADDR, 32'h0, 32'hFFFFFFFF, `E1RX_RESP_OKAY);
		line_on = 1'b1;
		run(10'h324, 1'b0, 700);
		run(10'h209, 1'b1, 1280);
		run(10'h10A, 1'b1, 1280);
		run(10'h30B, 1'b1, 1280);
		crc_off = 4'h0;
		run(10'h30B, 1'b1, 1280);
		run(10'h3C8, 1'b0, 600);
		results();
	end
endmodule
